// ### pkg/tc16_pkg.sv
// Shared constants for the 16-bit timer with input capture.
// Assumes an 8-bit processor bus with a 4-bit byte address.
`default_nettype none

package tc16_pkg;

	// ---------------------------------------------------------------
	// Bus geometry
	// ---------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// ---------------------------------------------------------------
	// Byte locations
	// ---------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL_A     = 4'h0;
	localparam logic [3:0] OFS_CTRL_B     = 4'h1;
	localparam logic [3:0] OFS_COUNT_LO   = 4'h2;
	localparam logic [3:0] OFS_COUNT_HI   = 4'h3;
	localparam logic [3:0] OFS_CAPTURE_LO = 4'h4;
	localparam logic [3:0] OFS_CAPTURE_HI = 4'h5;
	localparam logic [3:0] OFS_FLAGS      = 4'h6;
	localparam logic [3:0] OFS_IRQ_MASK   = 4'h7;
	localparam logic [3:0] OFS_CMP_CTRL   = 4'h8;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CTRL_A_WGM_LO  = 0;   // waveform_mode_select[1:0]
	localparam int CTRL_B_CS_LO   = 0;   // clock_source_select[2:0]
	localparam int CTRL_B_WGM_HI  = 3;   // waveform_mode_select[3:2]
	localparam int CTRL_B_EDGE    = 6;   // 1 = rising edge captures
	localparam int CTRL_B_NF_EN   = 7;   // noise_filter_enable
	localparam int FLAG_OVF       = 0;   // overflow_flag
	localparam int FLAG_CAP       = 5;   // capture_flag
	localparam int CMP_CAP_SEL    = 2;   // comparator_capture_select

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [15:0] RST_WORD  = 16'h0000;

	// ---------------------------------------------------------------
	// Counter limits and timing
	// ---------------------------------------------------------------
	localparam logic [15:0] CNT_MAX   = 16'hffff;
	localparam logic [15:0] TOP_8BIT  = 16'h00ff;
	localparam logic [15:0] TOP_9BIT  = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	localparam int NF_SAMPLES         = 4;
	localparam logic [2:0] SRC_SETTLE = 3'h7;  // Source change to capture
	localparam int PRESC_MIN_W        = 10;  // widest divide is 1024

	// Clock source codes
	localparam logic [2:0] CS_STOP    = 3'h0;
	localparam logic [2:0] CS_EXT_F   = 3'h6;
	localparam logic [2:0] CS_EXT_R   = 3'h7;

	// ---------------------------------------------------------------
	// Host command kinds
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		TC16_WR8,
		TC16_RD8,
		TC16_WR16,
		TC16_RD16
	} tc16_cmd_t;

endpackage

`default_nettype wire

// ### pkg/tc16_bus_if.sv
// Byte bus plus interrupt lines between processor and timer.
// Both ends run on the same sys_clk; strobes last one cycle.
`default_nettype none

interface tc16_bus_if;
	logic [3:0] addr;      // Byte location
	logic       wr;        // Write strobe
	logic       rd;        // Read strobe
	logic [7:0] wdata;     // Write data
	logic [7:0] rdata;     // Read data, one cycle after rd
	logic       ovf_irq;   // Overflow interrupt request
	logic       cap_irq;   // Capture interrupt request
	logic       ovf_ack;   // Overflow interrupt taken
	logic       cap_ack;   // Capture interrupt taken

	modport dev (
		input  addr, wr, rd, wdata, ovf_ack, cap_ack,
		output rdata, ovf_irq, cap_irq
	);
	modport host (
		output addr, wr, rd, wdata, ovf_ack, cap_ack,
		input  rdata, ovf_irq, cap_irq
	);
endinterface

`default_nettype wire

// ### core/tc16_timer.sv
// Timer end: 16-bit up/down counter, byte bus, shared high-byte
// holding register and input capture with optional noise filter.
// Assumes pins are synchronous to sys_clk and the host keeps byte
// order on 16-bit accesses.
`default_nettype none

module tc16_timer #(
	parameter int PRESC_W = 10
) (
	input  wire logic     sys_clk,           // System clock
	input  wire logic     rst_n,             // Async reset, active low
	tc16_bus_if.dev       bus,               // Processor side
	input  wire logic     capture_pin,       // Capture event input
	input  wire logic     comparator_output, // Comparator result
	input  wire logic     ext_tick_pin,      // External count source
	output logic          timer_tick         // Tick pulse, for view
);
	import tc16_pkg::*;

	// ---------------------------------------------------------------
	// Parameter check
	// ---------------------------------------------------------------
	if (PRESC_W < PRESC_MIN_W) begin : g_chk
		$error("PRESC_W too small for the widest divide");
	end

	typedef struct packed {
		logic [15:0]        cnt;
		logic [15:0]        icr;
		logic [7:0]         temp;
		logic [7:0]         ctl_a;
		logic [7:0]         ctl_b;
		logic [7:0]         cmp;
		logic [7:0]         msk;
		logic               ovf;
		logic               icf;
		logic               up;
		logic [PRESC_W-1:0] presc;
		logic [NF_SAMPLES-1:0] samp;
		logic               filt;
		logic               canc;
		logic               ext_q;
		logic [7:0]         rdata;
	} tc16_dev_state_t;

	tc16_dev_state_t s_reg;
	tc16_dev_state_t s_next;

	// ---------------------------------------------------------------
	// Mode decoding
	// ---------------------------------------------------------------
	function automatic logic [15:0] tc16_top(input logic [3:0] m,
	                                         input logic [15:0] icr);
		unique case (m)
			4'h1, 4'h5:                tc16_top = TOP_8BIT;
			4'h2, 4'h6:                tc16_top = TOP_9BIT;
			4'h3, 4'h7:                tc16_top = TOP_10BIT;
			4'h8, 4'ha, 4'hc, 4'he:    tc16_top = icr;
			default:                   tc16_top = CNT_MAX;
		endcase
	endfunction

	function automatic logic tc16_uses_icr(input logic [3:0] m);
		tc16_uses_icr = (m == 4'h8) || (m == 4'ha) ||
		                (m == 4'hc) || (m == 4'he);
	endfunction

	function automatic logic tc16_dual(input logic [3:0] m);
		tc16_dual = (m >= 4'h1 && m <= 4'h3) ||
		            (m >= 4'h8 && m <= 4'hb);
	endfunction

	function automatic logic tc16_fast(input logic [3:0] m);
		tc16_fast = (m >= 4'h5 && m <= 4'h7) || (m >= 4'he);
	endfunction

	// Tick from clock select; the divide taps share one prescaler
	function automatic logic tc16_tick(input logic [2:0] cs,
	                                   input logic [PRESC_W-1:0] p,
	                                   input logic rise,
	                                   input logic fall);
		unique case (cs)
			CS_STOP:  tc16_tick = 1'b0;
			3'h1:     tc16_tick = 1'b1;
			3'h2:     tc16_tick = &p[2:0];
			3'h3:     tc16_tick = &p[5:0];
			3'h4:     tc16_tick = &p[7:0];
			3'h5:     tc16_tick = &p[9:0];
			CS_EXT_F: tc16_tick = fall;
			CS_EXT_R: tc16_tick = rise;
		endcase
	endfunction

	logic [3:0]  mode;
	logic [15:0] top;
	logic        tick, raw, lvl, cap_evt;
	logic        ovf_set, ovf_clr, icf_clr, wr_lo_cnt;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		mode = {s_reg.ctl_b[CTRL_B_WGM_HI +: 2],
		        s_reg.ctl_a[CTRL_A_WGM_LO +: 2]};
		top = tc16_top(mode, s_reg.icr);

		// Clock select and prescaler
		s_next.ext_q = ext_tick_pin;
		if (s_reg.ctl_b[CTRL_B_CS_LO +: 3] == CS_STOP) begin
			s_next.presc = '0;
		end else begin
			s_next.presc = s_reg.presc + PRESC_W'(1);
		end
		tick = tc16_tick(s_reg.ctl_b[CTRL_B_CS_LO +: 3], s_reg.presc,
		                 ext_tick_pin & ~s_reg.ext_q,
		                 ~ext_tick_pin & s_reg.ext_q);

		// Counter sequence
		ovf_set = 1'b0;
		if (tick) begin
			if (tc16_dual(mode)) begin
				if (s_reg.cnt == RST_WORD) begin
					ovf_set = 1'b1;
				end
				// Turn at the ends, then step the new way
				if (s_reg.up && s_reg.cnt >= top) begin
					s_next.up = 1'b0;
				end else if (!s_reg.up && s_reg.cnt == RST_WORD) begin
					s_next.up = 1'b1;
				end
				s_next.cnt = s_next.up ? s_reg.cnt + 16'h0001
				                       : s_reg.cnt - 16'h0001;
			end else begin
				s_next.up  = 1'b1;
				s_next.cnt = (s_reg.cnt == top) ? RST_WORD
				                                : s_reg.cnt + 16'h0001;
				ovf_set = tc16_fast(mode) ? (s_reg.cnt == top)
				                          : (s_reg.cnt == CNT_MAX);
			end
		end

		// Capture source, sampling and noise filter
		raw = s_reg.cmp[CMP_CAP_SEL] ? comparator_output
		                             : capture_pin;
		s_next.samp = {s_reg.samp[NF_SAMPLES-2:0], raw};
		// Canceler always runs, so enabling it shows no false edge
		if (&s_reg.samp || ~|s_reg.samp) begin
			s_next.canc = s_reg.samp[0];
		end
		// Its own flop makes the fourth extra cycle over the chain
		lvl = s_reg.ctl_b[CTRL_B_NF_EN] ? s_reg.canc
		                                : s_reg.samp[0];
		s_next.filt = lvl;
		cap_evt = (lvl != s_reg.filt) &&
		          (lvl == s_reg.ctl_b[CTRL_B_EDGE]) &&
		          !tc16_uses_icr(mode);
		if (cap_evt) begin
			s_next.icr = s_reg.cnt;
		end

		// Processor reads; a low read latches the upper byte
		s_next.rdata = RST_BYTE;
		if (bus.rd) begin
			unique case (bus.addr)
				OFS_CTRL_A:   s_next.rdata = s_reg.ctl_a;
				OFS_CTRL_B:   s_next.rdata = s_reg.ctl_b;
				OFS_COUNT_LO: begin
					s_next.rdata = s_reg.cnt[7:0];
					s_next.temp  = s_reg.cnt[15:8];
				end
				OFS_CAPTURE_LO: begin
					s_next.rdata = s_reg.icr[7:0];
					s_next.temp  = s_reg.icr[15:8];
				end
				OFS_COUNT_HI, OFS_CAPTURE_HI:
					s_next.rdata = s_reg.temp;
				OFS_FLAGS: begin
					s_next.rdata[FLAG_OVF] = s_reg.ovf;
					s_next.rdata[FLAG_CAP] = s_reg.icf;
				end
				OFS_IRQ_MASK: s_next.rdata = s_reg.msk;
				OFS_CMP_CTRL: s_next.rdata = s_reg.cmp;
				default:      s_next.rdata = RST_BYTE;
			endcase
		end

		// Processor writes; they land after the counter update
		ovf_clr = 1'b0;
		icf_clr = 1'b0;
		wr_lo_cnt = bus.wr && (bus.addr == OFS_COUNT_LO);
		if (bus.wr) begin
			unique case (bus.addr)
				OFS_CTRL_A:   s_next.ctl_a = bus.wdata;
				OFS_CTRL_B:   s_next.ctl_b = bus.wdata;
				OFS_COUNT_HI, OFS_CAPTURE_HI:
					s_next.temp = bus.wdata;
				OFS_CAPTURE_LO: begin
					if (tc16_uses_icr(mode)) begin
						s_next.icr = {s_reg.temp, bus.wdata};
					end
				end
				OFS_FLAGS: begin
					ovf_clr = bus.wdata[FLAG_OVF];
					icf_clr = bus.wdata[FLAG_CAP];
				end
				OFS_IRQ_MASK: s_next.msk = bus.wdata;
				OFS_CMP_CTRL: s_next.cmp = bus.wdata;
				default:      ;
			endcase
		end
		if (wr_lo_cnt) begin
			s_next.cnt = {s_reg.temp, bus.wdata};
		end

		// Flags: a set in the clearing cycle survives
		s_next.ovf = (s_reg.ovf & ~(ovf_clr | bus.ovf_ack)) | ovf_set;
		s_next.icf = (s_reg.icf & ~(icf_clr | bus.cap_ack)) |
		             cap_evt;
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg       <= '0;
			s_reg.up    <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign bus.rdata   = s_reg.rdata;
	assign bus.ovf_irq = s_reg.ovf & s_reg.msk[FLAG_OVF];
	assign bus.cap_irq = s_reg.icf & s_reg.msk[FLAG_CAP];
	assign timer_tick  = tick;

endmodule

`default_nettype wire

// ### core/tc16_host.sv
// Processor end: turns user commands into ordered byte accesses.
// Assumes the timer answers a read one cycle after the strobe.
`default_nettype none

module tc16_host (
	input  wire logic             sys_clk,     // System clock
	input  wire logic             rst_n,       // Async reset, active low
	tc16_bus_if.host              bus,         // Timer side
	input  wire logic             cmd_valid,   // Command request
	output logic                  cmd_ready,   // Idle, takes command
	input  wire tc16_pkg::tc16_cmd_t cmd_kind, // Access kind
	input  wire logic [3:0]       cmd_addr,    // Byte, or low byte
	input  wire logic [15:0]      cmd_data,    // Write data
	output logic                  rsp_valid,   // Command done pulse
	output logic [15:0]           rsp_data,    // Read result
	input  wire logic             ovf_take,    // Overflow irq taken
	input  wire logic             cap_take,    // Capture irq taken
	output logic                  ovf_irq,     // Overflow request
	output logic                  cap_irq      // Capture request
);
	import tc16_pkg::*;

	typedef enum logic [2:0] {
		H_IDLE, H_WLO, H_RHI, H_RLO, H_RGAP, H_RLAST, H_CLR
	} tc16_hst_t;

	typedef struct packed {
		tc16_hst_t   st;
		logic [3:0]  addr;
		logic [15:0] data;
		logic        two;
		logic [7:0]  last_hi;
		logic        hi_known;
		logic        sel_q;
		logic        b_wr;
		logic        b_rd;
		logic [3:0]  b_addr;
		logic [7:0]  b_wdata;
		logic        rsp;
		logic        ovf_ack;
		logic        cap_ack;
		logic [2:0]  wait_n;
	} tc16_host_state_t;

	tc16_host_state_t h_reg;
	tc16_host_state_t h_next;

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_comb begin
		h_next = h_reg;
		h_next.b_wr = 1'b0;
		h_next.b_rd = 1'b0;
		h_next.rsp  = 1'b0;
		h_next.ovf_ack = ovf_take;
		h_next.cap_ack = cap_take;
		unique case (h_reg.st)
			H_IDLE: if (cmd_valid) begin
				h_next.addr = cmd_addr;
				h_next.data = cmd_data;
				h_next.two  = (cmd_kind == TC16_RD16);
				unique case (cmd_kind)
					TC16_WR8: begin
						h_next.b_wr    = 1'b1;
						h_next.b_addr  = cmd_addr;
						h_next.b_wdata = cmd_data[7:0];
						if (cmd_addr == OFS_COUNT_HI ||
						    cmd_addr == OFS_CAPTURE_HI) begin
							h_next.last_hi  = cmd_data[7:0];
							h_next.hi_known = 1'b1;
						end
						if (cmd_addr == OFS_CMP_CTRL &&
						    cmd_data[CMP_CAP_SEL] != h_reg.sel_q) begin
							// Source change may fake a capture
							h_next.sel_q = cmd_data[CMP_CAP_SEL];
							h_next.wait_n = SRC_SETTLE;
							h_next.st    = H_CLR;
						end else begin
							h_next.rsp = 1'b1;
						end
					end
					TC16_WR16: begin
						h_next.b_wr = 1'b1;
						if (h_reg.hi_known &&
						    h_reg.last_hi == cmd_data[15:8]) begin
							h_next.b_addr  = cmd_addr;
							h_next.b_wdata = cmd_data[7:0];
							h_next.rsp     = 1'b1;
						end else begin
							h_next.b_addr  = cmd_addr + 4'h1;
							h_next.b_wdata = cmd_data[15:8];
							h_next.last_hi  = cmd_data[15:8];
							h_next.hi_known = 1'b1;
							h_next.st       = H_WLO;
						end
					end
					TC16_RD8, TC16_RD16: begin
						// Any low read reloads the holding byte
						h_next.b_rd     = 1'b1;
						h_next.b_addr   = cmd_addr;
						h_next.hi_known = 1'b0;
						h_next.st = (cmd_kind == TC16_RD16) ? H_RHI
						                                    : H_RGAP;
					end
				endcase
			end
			H_WLO: begin
				h_next.b_wr    = 1'b1;
				h_next.b_addr  = h_reg.addr;
				h_next.b_wdata = h_reg.data[7:0];
				h_next.rsp     = 1'b1;
				h_next.st      = H_IDLE;
			end
			H_RHI: begin
				h_next.b_rd   = 1'b1;
				h_next.b_addr = h_reg.addr + 4'h1;
				h_next.st     = H_RLO;
			end
			H_RLO: begin
				h_next.data[7:0] = bus.rdata;
				h_next.st        = H_RLAST;
			end
			H_RGAP: h_next.st = H_RLAST;
			H_RLAST: begin
				if (h_reg.two) begin
					h_next.data[15:8] = bus.rdata;
				end else begin
					h_next.data = {8'h00, bus.rdata};
				end
				h_next.rsp = 1'b1;
				h_next.st  = H_IDLE;
			end
			H_CLR: begin
				// A faked capture lands only after the filter; clear later
				if (h_reg.wait_n != 3'h0) begin
					h_next.wait_n = h_reg.wait_n - 3'h1;
				end else begin
					h_next.b_wr    = 1'b1;
					h_next.b_addr  = OFS_FLAGS;
					h_next.b_wdata = 8'h01 << FLAG_CAP;
					h_next.rsp     = 1'b1;
					h_next.st      = H_IDLE;
				end
			end
			default: h_next.st = H_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			h_reg    <= '0;
			h_reg.st <= H_IDLE;
		end else begin
			h_reg <= h_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign bus.wr      = h_reg.b_wr;
	assign bus.rd      = h_reg.b_rd;
	assign bus.addr    = h_reg.b_addr;
	assign bus.wdata   = h_reg.b_wdata;
	assign bus.ovf_ack = h_reg.ovf_ack;
	assign bus.cap_ack = h_reg.cap_ack;
	assign cmd_ready   = (h_reg.st == H_IDLE);
	assign rsp_valid   = h_reg.rsp;
	assign rsp_data    = h_reg.data;
	assign ovf_irq     = bus.ovf_irq;
	assign cap_irq     = bus.cap_irq;

endmodule

`default_nettype wire

// ### dv/tc16_props.sv
// Concurrent checks on the byte bus between the host and timer ends.
// Assumes one sys_clk domain and the signals of one tc16_bus_if.
`default_nettype none

module tc16_props (
	input wire logic       sys_clk, // System clock
	input wire logic       rst_n,   // Async reset, active low
	input wire logic [3:0] addr,    // Byte location
	input wire logic       wr,      // Write strobe
	input wire logic       rd,      // Read strobe
	input wire logic [7:0] wdata,   // Write data
	input wire logic [7:0] rdata,   // Read data
	input wire logic       ovf_irq, // Overflow request
	input wire logic       cap_irq, // Capture request
	input wire logic       ovf_ack, // Overflow taken
	input wire logic       cap_ack  // Capture taken
);
	import tc16_pkg::*;

	logic [7:0] mask_reg, mask_next, ctrl_b_reg, ctrl_b_next;
	logic       clr_any;

	// ---------------------------------------------------------------
	// Shadow copies of written control bytes
	// ---------------------------------------------------------------
	always_comb begin
		mask_next = (wr && addr == OFS_IRQ_MASK) ? wdata : mask_reg;
		ctrl_b_next = (wr && addr == OFS_CTRL_B) ? wdata : ctrl_b_reg;
		clr_any = wr && (addr == OFS_FLAGS || addr == OFS_IRQ_MASK);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_reg <= RST_BYTE;
			ctrl_b_reg <= RST_BYTE;
		end else begin
			mask_reg <= mask_next;
			ctrl_b_reg <= ctrl_b_next;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
		else $error("read data not zero after an idle cycle");
	a_ctrl_readback: assert property (rd && addr == OFS_CTRL_B |=>
		(rdata & 8'hdf) == (ctrl_b_reg & 8'hdf))
		else $error("control byte B read back wrong");
	a_ovf_masked: assert property (ovf_irq |-> mask_reg[FLAG_OVF])
		else $error("overflow request while masked");
	a_cap_masked: assert property (cap_irq |-> mask_reg[FLAG_CAP])
		else $error("capture request while masked");
	a_ovf_ack_clear: assert property (ovf_ack |=> !ovf_irq)
		else $error("overflow request stayed after ack");
	a_cap_ack_clear: assert property (cap_ack |=> !cap_irq)
		else $error("capture request stayed after ack");
	a_cap_one_clears: assert property (wr && addr == OFS_FLAGS &&
		wdata[FLAG_CAP] |=> !cap_irq)
		else $error("writing one left capture flag set");
	a_cap_zero_keeps: assert property (wr && addr == OFS_FLAGS &&
		!wdata[FLAG_CAP] && cap_irq |=> cap_irq)
		else $error("writing zero cleared capture flag");
	a_cap_flag_holds: assert property (cap_irq && !cap_ack &&
		!clr_any |=> cap_irq)
		else $error("capture request dropped by itself");
	a_ovf_flag_holds: assert property (ovf_irq && !ovf_ack &&
		!clr_any |=> ovf_irq)
		else $error("overflow request dropped by itself");

endmodule

`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench: host end and timer end joined by one bus.
// Assumes tc16_pkg, tc16_bus_if, both ends and tc16_props compiled.
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import tc16_pkg::*;

	logic        sys_clk = 0, rst_n = 0, cmd_valid = 0;
	logic        ovf_take = 0, cap_take = 0, pin = 0, cmp = 0, ext = 0;
	tc16_cmd_t   cmd_kind = TC16_WR8;
	logic [3:0]  cmd_addr = 4'h0;
	logic [15:0] cmd_data = 16'h0000;
	logic        cmd_ready, rsp_valid, ovf_irq, cap_irq, timer_tick;
	logic [15:0] rsp_data, v;
	logic [16:0] exp_q[$];
	logic [16:0] note;
	int          n_errors = 0, checked = 0, ticks = 0, n, c0, c1;
	int          seed = 22657;

	tc16_bus_if bus_i ();
	tc16_timer tc16_timer_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.bus(bus_i), .capture_pin(pin), .comparator_output(cmp),
		.ext_tick_pin(ext), .timer_tick(timer_tick));
	tc16_host tc16_host_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.bus(bus_i), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .ovf_take(ovf_take),
		.cap_take(cap_take), .ovf_irq(ovf_irq), .cap_irq(cap_irq));
	tc16_props tc16_props_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.addr(bus_i.addr), .wr(bus_i.wr), .rd(bus_i.rd),
		.wdata(bus_i.wdata), .rdata(bus_i.rdata), .ovf_irq(bus_i.ovf_irq),
		.cap_irq(bus_i.cap_irq), .ovf_ack(bus_i.ovf_ack),
		.cap_ack(bus_i.cap_ack));

	always #12.5 sys_clk = ~sys_clk;

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] e, g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Entered just after a rising edge; returns on one
	task automatic cmd(input tc16_cmd_t k, input logic [3:0] a,
		input logic [15:0] d, input logic is_rd);
		int t;
		t = 0;
		exp_q.push_back({is_rd, d});
		cmd_kind <= k;
		cmd_addr <= a;
		cmd_data <= d;
		cmd_valid <= 1'b1;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		do begin
			@(negedge sys_clk);
			t++;
		end while (rsp_valid !== 1'b1 && t < 20);
		if (t >= 20)
			chk("rsp_valid", 16'h0001, 16'h0000);
		@(posedge sys_clk);
	endtask

	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		cmd(TC16_WR8, a, {8'h00, d}, 1'b0);
	endtask
	task automatic wr16(input logic [3:0] a, input logic [15:0] d);
		cmd(TC16_WR16, a, d, 1'b0);
	endtask
	task automatic rd8(input logic [3:0] a, input logic [7:0] e);
		cmd(TC16_RD8, a, {8'h00, e}, 1'b1);
	endtask
	task automatic rd16(input logic [3:0] a, input logic [15:0] e);
		cmd(TC16_RD16, a, e, 1'b1);
	endtask

	// Irq lines are compared mid-cycle, away from the edge
	task automatic irqs(input logic [1:0] e);
		@(negedge sys_clk);
		chk("irq lines", {14'h0000, e}, {14'h0000, ovf_irq, cap_irq});
		@(posedge sys_clk);
	endtask
	task automatic take(input logic o, input logic c);
		ovf_take <= o;
		cap_take <= c;
		@(posedge sys_clk);
		ovf_take <= 1'b0;
		cap_take <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic edge_in(input logic via_cmp, input logic lvl);
		if (via_cmp)
			cmp <= lvl;
		else
			pin <= lvl;
		repeat (12) @(posedge sys_clk);
	endtask
	task automatic lat(output int c);
		pin <= ~pin;
		c = 0;
		do begin
			@(negedge sys_clk);
			c++;
		end while (cap_irq !== 1'b1 && c < 30);
		@(posedge sys_clk);
		take(1'b0, 1'b1);
		irqs(2'b00);
	endtask

	// ---------------------------------------------------------------
	// Checker of responses and tick counter
	// ---------------------------------------------------------------
	always @(negedge sys_clk) begin
		if (timer_tick === 1'b1)
			ticks++;
		if (rsp_valid === 1'b1)
			chk("cmd_ready", 16'h0001, {15'h0000, cmd_ready});
		if (rsp_valid === 1'b1 && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			if (note[16])
				chk("rsp_data", note[15:0], rsp_data);
		end
	end

	task automatic finish_test();
		$display("checked %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge sys_clk);
		n_errors++;
		finish_test();
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		rd8(OFS_CTRL_B, 8'h00);
		rd16(OFS_COUNT_LO, 16'h0000);
		wr16(OFS_COUNT_LO, 16'h00fd);
		rd16(OFS_COUNT_LO, 16'h00fd);
		wr8(OFS_CTRL_A, 8'h01);
		ticks = 0;
		wr8(OFS_CTRL_B, 8'h01);
		repeat (4) @(posedge sys_clk);
		wr8(OFS_CTRL_B, 8'h00);
		n = ticks;
		chk("ticks running", 16'h0001, 16'(n > 4));
		rd16(OFS_COUNT_LO, 16'h0101 - 16'(n));
		chk("ticks stopped", 16'(n), 16'(ticks));
		$display("test count sequence done");
		wr8(OFS_CTRL_A, 8'h00);
		wr16(OFS_COUNT_LO, 16'hfffe);
		ticks = 0;
		wr8(OFS_CTRL_B, 8'h01);
		repeat (3) @(posedge sys_clk);
		wr8(OFS_CTRL_B, 8'h00);
		rd16(OFS_COUNT_LO, 16'hfffe + 16'(ticks));
		rd8(OFS_FLAGS, 8'h01);
		wr8(OFS_IRQ_MASK, 8'h21);
		irqs(2'b10);
		take(1'b1, 1'b0);
		irqs(2'b00);
		$display("test overflow done");
		wr8(OFS_CTRL_B, 8'h40);
		v = 16'($random(seed));
		wr16(OFS_COUNT_LO, v);
		edge_in(1'b0, 1'b1);
		irqs(2'b01);
		rd16(OFS_CAPTURE_LO, v);
		rd8(OFS_FLAGS, 8'h20);
		wr8(OFS_FLAGS, 8'h00);
		irqs(2'b01);
		wr8(OFS_FLAGS, 8'h20);
		edge_in(1'b0, 1'b0);
		irqs(2'b00);
		wr8(OFS_CTRL_B, 8'h00);
		wr16(OFS_COUNT_LO, v ^ 16'h5a5a);
		edge_in(1'b0, 1'b1);
		edge_in(1'b0, 1'b0);
		v = 16'($random(seed));
		wr16(OFS_COUNT_LO, v);
		edge_in(1'b0, 1'b1);
		edge_in(1'b0, 1'b0);
		rd16(OFS_CAPTURE_LO, v);
		take(1'b0, 1'b1);
		irqs(2'b00);
		$display("test capture done");
		edge_in(1'b0, 1'b1);
		lat(c0);
		wr8(OFS_CTRL_B, 8'h80);
		edge_in(1'b0, 1'b1);
		lat(c1);
		chk("filter delay", 16'(c0 + 4), 16'(c1));
		pin <= 1'b1;
		repeat (3) @(posedge sys_clk);
		pin <= 1'b0;
		repeat (12) @(posedge sys_clk);
		irqs(2'b00);
		edge_in(1'b0, 1'b1);
		wr8(OFS_CMP_CTRL, 8'h04);
		irqs(2'b00);
		edge_in(1'b0, 1'b1);
		edge_in(1'b0, 1'b0);
		irqs(2'b00);
		edge_in(1'b1, 1'b1);
		edge_in(1'b1, 1'b0);
		irqs(2'b01);
		take(1'b0, 1'b1);
		$display("test filter and source done");
		wr8(OFS_CTRL_B, 8'h18);
		wr16(OFS_CAPTURE_LO, 16'h01aa);
		wr16(OFS_COUNT_LO, 16'h0177);
		rd16(OFS_COUNT_LO, 16'h0177);
		edge_in(1'b1, 1'b1);
		edge_in(1'b1, 1'b0);
		irqs(2'b00);
		rd16(OFS_CAPTURE_LO, 16'h01aa);
		wr8(OFS_CTRL_B, 8'h00);
		wr16(OFS_CAPTURE_LO, 16'h5a5a);
		rd16(OFS_CAPTURE_LO, 16'h01aa);
		$display("test capture top mode done");
		repeat (4) @(posedge sys_clk);
		finish_test();
	end

endmodule

`default_nettype wire
